// >>> inc/rcap_pkg.sv
// Purpose: Constants and types for the remote capability register bank
// Assumes: Byte-wide register access at documented offsets
// Notes:   One copy of each register per port
`default_nettype none
package rcap_pkg;
  localparam logic [7:0] RCAP_LOW_OFFSET  = 8'h20;
  localparam logic [7:0] RCAP_HIGH_OFFSET = 8'h21;
  localparam logic [7:0] RCAP_LOW_RESET   = 8'h00;
  localparam logic [7:0] RCAP_HIGH_RESET  = 8'h00;
  localparam int         RCAP_LOCK_BIT    = 7;
  localparam int         RCAP_MODE0_BIT   = 6;
  localparam int         RCAP_FREQ_BIT    = 5;
  localparam int         RCAP_EQ_BIT      = 4;
  localparam int         RCAP_TWO_BIT     = 3;
  localparam int         RCAP_ROLE_BIT    = 2;
  // Bits that the back channel may reload in the low register
  localparam logic [7:0] RCAP_LOW_AUTO    = 8'h7F;
  localparam logic [7:0] RCAP_HIGH_MASK   = 8'h03;
  localparam int         RCAP_PORTS       = 2;
  // Mode codes of the fast control channel
  typedef enum logic [2:0] {
    RCAP_MODE_NORMAL   = 3'h0,
    RCAP_MODE_GPIO1    = 3'h1,
    RCAP_MODE_GPIO2    = 3'h2,
    RCAP_MODE_GPIO4    = 3'h3,
    RCAP_MODE_RSVD4    = 3'h4,
    RCAP_MODE_RSVD5    = 3'h5,
    RCAP_MODE_FWD_SPI  = 3'h6,
    RCAP_MODE_REV_SPI  = 3'h7
  } rcap_mode_t;
endpackage : rcap_pkg
`default_nettype wire

// >>> rtl/rcap_mem.sv
// Purpose: Two-port-copy byte store for one capability register
// Assumes: One write source per cycle, chosen upstream
// Notes:   Read data is registered
`default_nettype none
module rcap_mem
  import rcap_pkg::*;
#(
  parameter int         WIDTH = 8,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic             wport,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             rport,
  output logic      [WIDTH-1:0] rdata,
  output logic      [WIDTH-1:0] cell0,
  output logic      [WIDTH-1:0] cell1
);
  // Refused at elaboration: reset value and store are one byte wide
  if (WIDTH != 8) begin : g_bad_width
    $error("rcap_mem supports WIDTH 8 only");
  end
  // Storage per port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cell0 <= RESET;
      cell1 <= RESET;
    end else if (we) begin
      if (wport) cell1 <= wdata;
      else       cell0 <= wdata;
    end
  end
  // Registered read of selected copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= RESET;
    else        rdata <= rport ? cell1 : cell0;
  end
endmodule : rcap_mem
`default_nettype wire

// >>> rtl/rcap_lock_merge.sv
// Purpose: Builds the next value of one port's capability pair
// Assumes: Software write and automatic load may land together
// Notes:   Software write wins for the bytes it touches
`default_nettype none
module rcap_lock_merge
  import rcap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] low_cur,
  input  wire logic [7:0] high_cur,
  input  wire logic       auto_ld,
  input  wire logic [7:0] auto_low,
  input  wire logic [1:0] auto_high,
  input  wire logic       sw_low_we,
  input  wire logic       sw_high_we,
  input  wire logic [7:0] sw_data,
  output logic            low_we,
  output logic            high_we,
  output logic      [7:0] low_next,
  output logic      [7:0] high_next
);
  logic do_auto;
  // Combinational only; clocked ports kept for a uniform hookup
  always_comb begin
    do_auto   = auto_ld && !low_cur[RCAP_LOCK_BIT]; // RQ1
    low_next  = low_cur;
    high_next = high_cur;
    if (do_auto) begin
      // Both bytes move in one cycle
      low_next  = (low_cur & ~RCAP_LOW_AUTO)
                | (auto_low & RCAP_LOW_AUTO); // RQ4 RQ14
      high_next = {6'h00, auto_high}; // RQ3
    end
    if (sw_low_we)  low_next  = sw_data; // RQ2
    if (sw_high_we) high_next = sw_data & RCAP_HIGH_MASK; // RQ2
    low_we  = do_auto || sw_low_we;
    high_we = do_auto || sw_high_we;
  end
  wire unused_clk = clk ^ rst_n;
endmodule : rcap_lock_merge
`default_nettype wire

// >>> rtl/rcap_bank.sv
// What this block does
// [RQ1] Lock bit stops automatic capability reloads
// [RQ2] Locked values equal last software writes
// [RQ3] Bit 6 is mode LSB; upper bits high
// [RQ4] After lock, unlocked fields load from back channel
// [RQ5] Software writing values must also set lock
// [RQ6] Bit 5 drives frequency training pattern
// [RQ7] Bit 4 drives equalizer training pattern
// [RQ8] Bit 3 shows two-lane capability
// [RQ9] Bit 2 role: 0 primary, 1 secondary
// [RQ10] Separate copy per port, selectable
// [RQ11] Lock, mode and eq bits reset zero
// [RQ12] Port select ignored with second address enabled
// [RQ13] Three-bit mode encodes channel modes
// [RQ14] Automatic load updates both registers together
//
// Purpose: Per-port shadow of the remote deserializer capabilities
// Assumes: Byte register port, one access per cycle, RX lock is a level
// Notes:   Read data and REG_RVALID appear two cycles after REG_RD
`default_nettype none
module rcap_bank
  import rcap_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RESETN,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic       REG_SECOND_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       SECOND_PORT_SELECT,
  input  wire logic       SECOND_ADDRESS_ENABLE,
  input  wire logic [1:0] RX_LOCK,
  input  wire logic [1:0] CAP_VALID,
  input  wire logic [7:0] CAP_LOW_P0,
  input  wire logic [1:0] CAP_HIGH_P0,
  input  wire logic [7:0] CAP_LOW_P1,
  input  wire logic [1:0] CAP_HIGH_P1,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  output logic      [1:0] FREQ_TRAINING_REQUEST,
  output logic      [1:0] EQUALIZER_TRAINING_REQUEST,
  output logic      [1:0] TWO_LANE_CAPABLE,
  output logic      [1:0] CHANNEL_ROLE,
  output logic      [1:0] CAPABILITY_LOCK,
  output logic      [2:0] FAST_CTRL_CHANNEL_MODE_P0,
  output logic      [2:0] FAST_CTRL_CHANNEL_MODE_P1
);
  logic       port_sel;
  logic       hit_low;
  logic       hit_high;
  logic [1:0] lock_reg;
  logic [1:0] load_pend;
  logic [7:0] low_c0, low_c1, high_c0, high_c1;
  logic [7:0] low_rd, high_rd;
  logic [1:0] low_we_p, high_we_p;
  logic [7:0] low_nx [RCAP_PORTS];
  logic [7:0] high_nx [RCAP_PORTS];
  logic       rd_high_reg;
  logic       low_we, high_we, wport;
  logic [7:0] low_wd, high_wd;

  // Port select: second address wins, else select bit when enable clear
  always_comb begin
    if (SECOND_ADDRESS_ENABLE)
      port_sel = REG_SECOND_ADDR; // RQ12
    else
      port_sel = SECOND_PORT_SELECT; // RQ10 RQ12
  end

  // Address decode
  always_comb begin
    hit_low  = 1'b0;
    hit_high = 1'b0;
    if (REG_ADDR == RCAP_LOW_OFFSET)       hit_low  = 1'b1;
    else if (REG_ADDR == RCAP_HIGH_OFFSET) hit_high = 1'b1;
  end

  // Software write aimed at port 1; a port 0 auto load then yields the store
  logic sw_p1;
  assign sw_p1 = REG_WR && (hit_low || hit_high) && port_sel;

  // Load once per lock rise; a pending load waits for valid capabilities
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lock_reg  <= 2'b00;
      load_pend <= 2'b00;
    end else begin
      lock_reg <= RX_LOCK;
      for (int p = 0; p < RCAP_PORTS; p++) begin
        if (!RX_LOCK[p])
          load_pend[p] <= 1'b0;
        else if (RX_LOCK[p] && !lock_reg[p])
          load_pend[p] <= 1'b1; // RQ4
        // Stay armed while the shared store is taken by the other port
        else if (CAP_VALID[p] && (p == 0 ? !sw_p1 : wport))
          load_pend[p] <= 1'b0;
      end
    end
  end

  // Merge per port
  for (genvar p = 0; p < RCAP_PORTS; p++) begin : g_port
    rcap_lock_merge u_merge (
      .clk        (SYS_CLK),
      .rst_n      (RESETN),
      .low_cur    (p == 0 ? low_c0 : low_c1),
      .high_cur   (p == 0 ? high_c0 : high_c1),
      .auto_ld    (load_pend[p] && CAP_VALID[p] && RX_LOCK[p]
                   && (p != 0 || !sw_p1)),
      .auto_low   (p == 0 ? CAP_LOW_P0 : CAP_LOW_P1),
      .auto_high  (p == 0 ? CAP_HIGH_P0 : CAP_HIGH_P1),
      .sw_low_we  (REG_WR && hit_low && (port_sel == 1'(p))),
      .sw_high_we (REG_WR && hit_high && (port_sel == 1'(p))),
      .sw_data    (REG_WDATA),
      .low_we     (low_we_p[p]),
      .high_we    (high_we_p[p]),
      .low_next   (low_nx[p]),
      .high_next  (high_nx[p])
    );
  end

  // Only one port written per cycle at the store; port 0 first
  always_comb begin
    wport   = !low_we_p[0] && !high_we_p[0];
    low_we  = wport ? low_we_p[1] : low_we_p[0];
    high_we = wport ? high_we_p[1] : high_we_p[0];
    low_wd  = wport ? low_nx[1] : low_nx[0];
    high_wd = wport ? high_nx[1] : high_nx[0];
  end

  rcap_mem #(.WIDTH(8), .RESET(RCAP_LOW_RESET)) u_low ( // RQ11
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .we    (low_we),
    .wport (wport),
    .wdata (low_wd),
    .rport (port_sel),
    .rdata (low_rd),
    .cell0 (low_c0),
    .cell1 (low_c1)
  );

  rcap_mem #(.WIDTH(8), .RESET(RCAP_HIGH_RESET)) u_high (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .we    (high_we),
    .wport (wport),
    .wdata (high_wd),
    .rport (port_sel),
    .rdata (high_rd),
    .cell0 (high_c0),
    .cell1 (high_c1)
  );

  // Read strobe tracking; the store answers one cycle after the strobe
  logic rd_hit_reg;
  logic rd_pend_reg;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_pend_reg <= 1'b0;
      rd_high_reg <= 1'b0;
      rd_hit_reg  <= 1'b0;
    end else begin
      rd_pend_reg <= REG_RD;
      rd_high_reg <= hit_high;
      rd_hit_reg  <= hit_low || hit_high;
    end
  end

  // Answer registered again so the pins come from flops; costs a cycle.
  // Unmapped addresses read zero; data stands until the next read.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RVALID <= 1'b0;
      REG_RDATA  <= 8'h00;
    end else begin
      REG_RVALID <= rd_pend_reg;
      if (rd_pend_reg) begin
        if (!rd_hit_reg)      REG_RDATA <= 8'h00;
        else if (rd_high_reg) REG_RDATA <= high_rd & RCAP_HIGH_MASK;
        else                  REG_RDATA <= low_rd;
      end
    end
  end

  // Field outputs registered from the store
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FREQ_TRAINING_REQUEST      <= 2'b00;
      EQUALIZER_TRAINING_REQUEST <= 2'b00;
      TWO_LANE_CAPABLE           <= 2'b00;
      CHANNEL_ROLE               <= 2'b00;
      CAPABILITY_LOCK            <= 2'b00;
      FAST_CTRL_CHANNEL_MODE_P0  <= RCAP_MODE_NORMAL;
      FAST_CTRL_CHANNEL_MODE_P1  <= RCAP_MODE_NORMAL;
    end else begin
      FREQ_TRAINING_REQUEST <= {low_c1[RCAP_FREQ_BIT],
                                low_c0[RCAP_FREQ_BIT]}; // RQ6
      EQUALIZER_TRAINING_REQUEST <= {low_c1[RCAP_EQ_BIT],
                                     low_c0[RCAP_EQ_BIT]}; // RQ7
      TWO_LANE_CAPABLE <= {low_c1[RCAP_TWO_BIT],
                           low_c0[RCAP_TWO_BIT]}; // RQ8
      CHANNEL_ROLE <= {low_c1[RCAP_ROLE_BIT],
                       low_c0[RCAP_ROLE_BIT]}; // RQ9
      CAPABILITY_LOCK <= {low_c1[RCAP_LOCK_BIT], low_c0[RCAP_LOCK_BIT]};
      FAST_CTRL_CHANNEL_MODE_P0 <= {high_c0[1:0],
                                    low_c0[RCAP_MODE0_BIT]}; // RQ3 RQ13
      FAST_CTRL_CHANNEL_MODE_P1 <= {high_c1[1:0],
                                    low_c1[RCAP_MODE0_BIT]}; // RQ3 RQ13
    end
  end

  // Checks
  // A locked copy only moves under a software write to that copy
  chk_lock_holds: assert property ( // RQ1
    @(posedge SYS_CLK) disable iff (!RESETN)
    low_c0[RCAP_LOCK_BIT] && !(REG_WR && !port_sel)
    |=> $stable(low_c0) && $stable(high_c0))
    else $error("locked port 0 copy changed");
  chk_lock_holds_p1: assert property ( // RQ1
    @(posedge SYS_CLK) disable iff (!RESETN)
    low_c1[RCAP_LOCK_BIT] && !(REG_WR && port_sel)
    |=> $stable(low_c1) && $stable(high_c1))
    else $error("locked port 1 copy changed");
  // The lock bit itself is never taken from the back channel
  chk_lock_kept: assert property ( // RQ1 RQ4
    @(posedge SYS_CLK) disable iff (!RESETN)
    !REG_WR |=> $stable(low_c0[RCAP_LOCK_BIT])
    && $stable(low_c1[RCAP_LOCK_BIT]))
    else $error("lock bit changed without a write");
  // Every software write lands, even against an auto load
  chk_sw_write: assert property ( // RQ2
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_WR && hit_low && !port_sel |=> low_c0 == $past(REG_WDATA))
    else $error("software write lost");
  chk_sw_write_p1: assert property ( // RQ2
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_WR && hit_low && port_sel |=> low_c1 == $past(REG_WDATA))
    else $error("port 1 software write lost");
  chk_high_write: assert property ( // RQ2 RQ3
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_WR && hit_high && !port_sel
    |=> high_c0 == ($past(REG_WDATA) & RCAP_HIGH_MASK))
    else $error("mode bits write lost");
  // Auto load moves both bytes of a port in one cycle
  chk_auto_load: assert property ( // RQ4 RQ14
    @(posedge SYS_CLK) disable iff (!RESETN)
    load_pend[0] && CAP_VALID[0] && RX_LOCK[0] && !low_c0[RCAP_LOCK_BIT]
    && !REG_WR |=> low_c0[6:0] == $past(CAP_LOW_P0[6:0])
    && high_c0[1:0] == $past(CAP_HIGH_P0))
    else $error("auto load incomplete");
  chk_auto_load_p1: assert property ( // RQ4 RQ14
    @(posedge SYS_CLK) disable iff (!RESETN)
    load_pend[1] && CAP_VALID[1] && RX_LOCK[1] && !low_c1[RCAP_LOCK_BIT]
    && !REG_WR && wport |=> low_c1[6:0] == $past(CAP_LOW_P1[6:0])
    && high_c1[1:0] == $past(CAP_HIGH_P1))
    else $error("port 1 auto load incomplete");
  // Field pins trail the store by one cycle
  chk_freq_out: assert property ( // RQ6
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> FREQ_TRAINING_REQUEST
    == {$past(low_c1[RCAP_FREQ_BIT]), $past(low_c0[RCAP_FREQ_BIT])})
    else $error("freq request mismatch");
  chk_eq_out: assert property ( // RQ7
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> EQUALIZER_TRAINING_REQUEST
    == {$past(low_c1[RCAP_EQ_BIT]), $past(low_c0[RCAP_EQ_BIT])})
    else $error("eq request mismatch");
  chk_two_lane: assert property ( // RQ8
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> TWO_LANE_CAPABLE
    == {$past(low_c1[RCAP_TWO_BIT]), $past(low_c0[RCAP_TWO_BIT])})
    else $error("two lane mismatch");
  chk_role_out: assert property ( // RQ9
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> CHANNEL_ROLE
    == {$past(low_c1[RCAP_ROLE_BIT]), $past(low_c0[RCAP_ROLE_BIT])})
    else $error("role mismatch");
  chk_lock_out: assert property ( // RQ1
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> CAPABILITY_LOCK
    == {$past(low_c1[RCAP_LOCK_BIT]), $past(low_c0[RCAP_LOCK_BIT])})
    else $error("lock output mismatch");
  chk_mode_out: assert property ( // RQ3 RQ13
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> FAST_CTRL_CHANNEL_MODE_P1 ==
    {$past(high_c1[1:0]), $past(low_c1[RCAP_MODE0_BIT])})
    else $error("mode mismatch");
  chk_mode_out_p0: assert property ( // RQ3 RQ13
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> FAST_CTRL_CHANNEL_MODE_P0 ==
    {$past(high_c0[1:0]), $past(low_c0[RCAP_MODE0_BIT])})
    else $error("port 0 mode mismatch");
  chk_port_route: assert property ( // RQ10 RQ12
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_WR && hit_low && port_sel |=> $stable(low_c0))
    else $error("wrong port written");
  // Read answer stands two cycles after the strobe
  chk_read_valid: assert property ( // RQ10
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_RD |-> ##2 REG_RVALID)
    else $error("read valid missing");
  chk_read_low: assert property ( // RQ10
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_RD && hit_low && !port_sel |-> ##2 REG_RDATA == $past(low_c0, 2))
    else $error("port 0 low read mismatch");
  chk_read_high_p1: assert property ( // RQ3 RQ10
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_RD && hit_high && port_sel
    |-> ##2 REG_RDATA == ($past(high_c1, 2) & RCAP_HIGH_MASK))
    else $error("port 1 high read mismatch");
  chk_read_unmapped: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    REG_RD && !hit_low && !hit_high |-> ##2 REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  cov_auto: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    load_pend[1] && CAP_VALID[1] && RX_LOCK[1]);
  cov_locked_ld: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    load_pend[0] && CAP_VALID[0] && low_c0[RCAP_LOCK_BIT]);
  cov_rd_port1: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    REG_RD && port_sel && hit_high);
  cov_port_clash: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    load_pend[0] && CAP_VALID[0] && RX_LOCK[0] && sw_p1);
  cov_rev_spi: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    FAST_CTRL_CHANNEL_MODE_P1 == RCAP_MODE_REV_SPI);
endmodule : rcap_bank
`default_nettype wire

// >>> bench/rcap_remote_model.sv
// Purpose: Far-side deserializer that reports capabilities per port
// Assumes: Link request level per port from the bench
// Notes:   Words are inverted while not valid, no pull on these lines
`default_nettype none
module rcap_remote_model #(
  parameter int DLY0 = 2,
  parameter int DLY1 = 9
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] link_up,
  input  wire logic [7:0] rep_low0,
  input  wire logic [1:0] rep_high0,
  input  wire logic [7:0] rep_low1,
  input  wire logic [1:0] rep_high1,
  output logic      [1:0] rx_lock,
  output logic      [1:0] cap_valid,
  output logic      [7:0] low_p0,
  output logic      [1:0] high_p0,
  output logic      [7:0] low_p1,
  output logic      [1:0] high_p1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt0;
  logic [3:0] cnt1;
  // Lock first, capability words later: a slow port lags its lock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_lock   <= 2'h0;
      cap_valid <= 2'h0;
      cnt0      <= 4'h0;
      cnt1      <= 4'h0;
    end else begin
      rx_lock   <= link_up;
      cnt0      <= !link_up[0] ? 4'h0 : cnt0 + 4'(cnt0 != 4'(DLY0));
      cnt1      <= !link_up[1] ? 4'h0 : cnt1 + 4'(cnt1 != 4'(DLY1));
      cap_valid <= {link_up[1] && cnt1 == 4'(DLY1),
                    link_up[0] && cnt0 == 4'(DLY0)};
    end
  end
  // Stale words never repeat the last good value
  assign low_p0  = cap_valid[0] ? rep_low0 : ~rep_low0;
  assign high_p0 = cap_valid[0] ? rep_high0 : ~rep_high0;
  assign low_p1  = cap_valid[1] ? rep_low1 : ~rep_low1;
  assign high_p1 = cap_valid[1] ? rep_high1 : ~rep_high1;
endmodule : rcap_remote_model
`default_nettype wire

// >>> bench/tb_rcap_bank.sv
// Purpose: Self-checking bench for the capability register bank
// Assumes: Byte strobes one cycle long, read answer two cycles later
// Notes:   Far side is the remote deserializer model
`default_nettype none
module tb_rcap_bank
  import rcap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sec = 1'b0;
  logic       psel = 1'b0, aen = 1'b0, rvalid;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lo0 = 8'h00, lo1 = 8'h00;
  logic [7:0] rdata, lp0, lp1;
  logic [1:0] link = 2'h0, hi0 = 2'h0, hi1 = 2'h0, lock, cvld, hp0, hp1;
  logic [1:0] freq, eq, two, role, clock_;
  logic [2:0] m0, m1;
  int         bad_count = 0;
  int         n_compared = 0;
  always #50 clk = ~clk;
  rcap_remote_model #(.DLY0(2), .DLY1(9)) model (.clk(clk), .rst_n(rst_n),
    .link_up(link), .rep_low0(lo0), .rep_high0(hi0), .rep_low1(lo1),
    .rep_high1(hi1), .rx_lock(lock), .cap_valid(cvld), .low_p0(lp0),
    .high_p0(hp0), .low_p1(lp1), .high_p1(hp1));
  rcap_bank uut (.SYS_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_SECOND_ADDR(sec), .REG_WDATA(wdata),
    .SECOND_PORT_SELECT(psel), .SECOND_ADDRESS_ENABLE(aen),
    .RX_LOCK(lock), .CAP_VALID(cvld), .CAP_LOW_P0(lp0), .CAP_HIGH_P0(hp0),
    .CAP_LOW_P1(lp1), .CAP_HIGH_P1(hp1), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .FREQ_TRAINING_REQUEST(freq),
    .EQUALIZER_TRAINING_REQUEST(eq), .TWO_LANE_CAPABLE(two),
    .CHANNEL_ROLE(role), .CAPABILITY_LOCK(clock_),
    .FAST_CTRL_CHANNEL_MODE_P0(m0), .FAST_CTRL_CHANNEL_MODE_P1(m1));
  task automatic chk(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Bounded wait on the read answer, data taken with the valid pulse
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    int i;
    i = 0;
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    do begin @(posedge clk); #1; i++; end while (rvalid !== 1'b1 && i < 4);
    chk({what, " valid"}, {7'h00, rvalid}, 8'h01);
    chk(what, rdata, exp);
  endtask : rd_chk
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Hang guard, over twenty times the expected run length
  initial begin
    #(5000 * 100);
    bad_count++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      psel <= p[0];
      rd_chk("low rst", 8'h20, 8'h00);
      rd_chk("high rst", 8'h21, 8'h00);
    end
    chk("outs rst", {freq, eq, two, role}, 8'h00);
    chk("lock mode rst", {clock_, m1, m0}, 8'h00);
    $display("test reset done");
    // Far side also offers bit 7, which must never load
    lo0 <= 8'hEC; hi0 <= 2'h2; link[0] <= 1'b1; psel <= 1'b0;
    repeat (20) @(posedge clk);
    rd_chk("low auto", 8'h20, 8'h6C);
    rd_chk("high auto", 8'h21, 8'h02);
    chk("mode p0", {5'h0, m0}, 8'h05);
    chk("fields p0", {freq[0], eq[0], two[0], role[0]}, 8'h0B);
    psel <= 1'b1;
    rd_chk("low p1 idle", 8'h20, 8'h00);
    $display("test autoload done");
    psel <= 1'b0;
    wr_reg(8'h20, 8'h90);
    wr_reg(8'h21, 8'h01);
    lo0 <= 8'h28; hi0 <= 2'h3; link[0] <= 1'b0;
    repeat (4) @(posedge clk);
    link[0] <= 1'b1;
    repeat (20) @(posedge clk);
    rd_chk("low frz", 8'h20, 8'h90);
    rd_chk("high frz", 8'h21, 8'h01);
    chk("frz p0", {eq[0], clock_[0], freq[0], two[0]}, 8'h0C);
    chk("mode frz", {5'h0, m0}, 8'h02);
    $display("test freeze done");
    lo1 <= 8'h14; hi1 <= 2'h1; link[1] <= 1'b1;
    repeat (20) @(posedge clk);
    psel <= 1'b1;
    rd_chk("low p1", 8'h20, 8'h14);
    chk("fields p1", {eq[1], role[1], two[1], freq[1]}, 8'h0C);
    aen <= 1'b1;
    rd_chk("addr one", 8'h20, 8'h90);
    sec <= 1'b1;
    rd_chk("addr two", 8'h20, 8'h14);
    aen <= 1'b0; sec <= 1'b0; psel <= 1'b0;
    wr_reg(8'h22, 8'hFF);
    rd_chk("unmapped", 8'h22, 8'h00);
    rd_chk("low kept", 8'h20, 8'h90);
    $display("test ports done");
    psel <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h20, {1'b1, c[0], 6'h00});
      wr_reg(8'h21, {6'h00, c[2:1]});
      repeat (3) @(posedge clk);
      #1;
      chk("mode p1", {5'h0, m1}, 8'(c));
    end
    $display("test modes done");
    results();
  end
endmodule : tb_rcap_bank
`default_nettype wire
